// ### design/pwmie_map.svh
// Register offsets, field layouts, reset values and masks for the
// PWM interrupt enable block.
// Assumes a 12-bit APB byte address within the PWM unit's window.
`ifndef PWMIE_MAP_SVH
`define PWMIE_MAP_SVH

// Byte offsets
`define PWMIE_SWBRK_OFS       12'h0dc
`define PWMIE_EVT_EN_OFS      12'h0e0
`define PWMIE_BRK_EN_OFS      12'h0e4
`define PWMIE_EVT_FLAG_OFS    12'h0e8
`define PWMIE_BRK_FLAG_OFS    12'h0ec
`define PWMIE_MODE_OFS        12'h0f0

// Reset values
`define PWMIE_EVT_EN_RST      32'h0000_0000
`define PWMIE_BRK_EN_RST      32'h0000_0000
`define PWMIE_EVT_FLAG_RST    32'h0000_0000
`define PWMIE_BRK_FLAG_RST    32'h0000_0000
`define PWMIE_MODE_RST        32'h0000_0000

// Implemented bits of each register
`define PWMIE_EVT_MASK        32'h3f3f_1515
`define PWMIE_BRK_EN_MASK     32'h0000_0707
`define PWMIE_BRK_FLAG_MASK   32'h0000_3f3f
`define PWMIE_MODE_MASK       32'h0000_0707

// Field positions, event enable / event flag layout
`define PWMIE_CMPD_LSB        24
`define PWMIE_CMPU_LSB        16
`define PWMIE_PERIOD_LSB      8
`define PWMIE_ZERO_LSB        0

// Field positions, brake enable and software brake layout
`define PWMIE_BRK_LVL_LSB     8
`define PWMIE_BRK_EDGE_LSB    0

// Field positions, brake flag layout
`define PWMIE_BFLG_LVL_LSB    8
`define PWMIE_BFLG_EDGE_LSB   0

// Field positions, mode register
`define PWMIE_MODE_COMPL_LSB  0
`define PWMIE_MODE_UPDN_LSB   8

`endif

// ### design/pwmie_pkg.sv
// Types shared by the PWM interrupt enable block.
// Assumes pwmie_map.svh supplies the numeric constants.
package pwmie_pkg;

    typedef logic [31:0] pwmie_word_type;

    // Register selected by an APB address
    typedef enum {
        PWMIE_SEL_NONE,
        PWMIE_SEL_SWBRK,
        PWMIE_SEL_EVT_EN,
        PWMIE_SEL_BRK_EN,
        PWMIE_SEL_EVT_FLAG,
        PWMIE_SEL_BRK_FLAG,
        PWMIE_SEL_MODE
    } pwmie_sel_type;

endpackage

// ### design/pwmie_top.sv
// Interrupt enable, flag and request logic of a six-channel PWM unit.
// Assumes an APB master on CORE_CLK, event strobes one cycle wide from
// the counters and brake detectors, and an external write-protect lock.
`timescale 1ns/1ps
`default_nettype none
`include "pwmie_map.svh"

module pwmie_top (
    input  wire logic        CORE_CLK,         // Peripheral clock
    input  wire logic        NRST,             // Async reset, active low
    input  wire logic        CLK_EN,           // Freezes all state when low
    input  wire logic        PSEL,             // APB select
    input  wire logic        PENABLE,          // APB access phase
    input  wire logic        PWRITE,           // APB direction
    input  wire logic [11:0] PADDR,            // APB byte address
    input  wire logic [31:0] PWDATA,           // APB write data
    output logic      [31:0] PRDATA,           // APB read data
    output logic             PREADY,           // APB ready
    output logic             PSLVERR,          // APB error, unmapped
    input  wire logic        WP_OPEN,          // Write-protect lock open
    input  wire logic [5:0]  CMP_DOWN_HIT,     // Down-count compare match
    input  wire logic [5:0]  CMP_UP_HIT,       // Up-count compare match
    input  wire logic [2:0]  PERIOD_HIT,       // Period match, ch 4/2/0
    input  wire logic [2:0]  CENTER_HIT,       // Center point, ch 4/2/0
    input  wire logic [2:0]  ZERO_HIT,         // Zero match, ch 4/2/0
    input  wire logic [2:0]  LEVEL_BRAKE_HIT,  // Level brake, per pair
    input  wire logic [2:0]  EDGE_BRAKE_HIT,   // Edge brake, per pair
    output logic      [2:0]  LEVEL_BRAKE_SW,   // Forced level brake pulse
    output logic      [2:0]  EDGE_BRAKE_SW,    // Forced edge brake pulse
    output logic             IRQ               // Interrupt request
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Address to register select
    function automatic pwmie_pkg::pwmie_sel_type decode(
        input logic [11:0] addr
    );
        pwmie_pkg::pwmie_sel_type sel;
        begin
            case (addr)
                `PWMIE_SWBRK_OFS:    sel = pwmie_pkg::PWMIE_SEL_SWBRK;
                `PWMIE_EVT_EN_OFS:   sel = pwmie_pkg::PWMIE_SEL_EVT_EN;
                `PWMIE_BRK_EN_OFS:   sel = pwmie_pkg::PWMIE_SEL_BRK_EN;
                `PWMIE_EVT_FLAG_OFS: sel = pwmie_pkg::PWMIE_SEL_EVT_FLAG;
                `PWMIE_BRK_FLAG_OFS: sel = pwmie_pkg::PWMIE_SEL_BRK_FLAG;
                `PWMIE_MODE_OFS:     sel = pwmie_pkg::PWMIE_SEL_MODE;
                default:             sel = pwmie_pkg::PWMIE_SEL_NONE;
            endcase
            return sel;
        end
    endfunction

    // Spread three even-channel bits onto positions 4, 2, 0
    function automatic logic [4:0] spread3(input logic [2:0] x);
        begin
            return {x[2], 1'b0, x[1], 1'b0, x[0]};
        end
    endfunction

    // Copy a per-pair bit onto both channels of the pair
    function automatic logic [5:0] pair2ch(input logic [2:0] x);
        begin
            return {x[2], x[2], x[1], x[1], x[0], x[0]};
        end
    endfunction

    // Sticky flag next value: a write-one clear, then hardware sets on top
    function automatic logic [31:0] w1c_update(
        input logic [31:0] flags,
        input logic        clr_en,
        input logic [31:0] clr,
        input logic [31:0] set,
        input logic [31:0] mask
    );
        logic [31:0] nxt;
        begin
            nxt = flags;
            if (clr_en)
                nxt = nxt & ~clr;
            return (nxt | set) & mask;
        end
    endfunction

    // Enable read-back: odd zero-point positions of complementary pairs
    // read 0 whatever was stored there
    function automatic logic [31:0] evt_en_view(
        input logic [31:0] en,
        input logic [2:0]  compl
    );
        logic [31:0] mask;
        begin
            mask    = 32'hffff_ffff;
            mask[5] = ~compl[2];
            mask[3] = ~compl[1];
            mask[1] = ~compl[0];
            return en & mask;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB access decode

    pwmie_pkg::pwmie_sel_type sel;
    logic                     setup_rd;
    logic                     acc_wr;
    logic                     wr_swbrk;
    logic                     wr_evt_en;
    logic                     wr_brk_en;
    logic                     wr_evt_flag;
    logic                     wr_brk_flag;
    logic                     wr_mode;

    assign sel      = decode(PADDR);
    assign PREADY   = CLK_EN;
    assign PSLVERR  = PSEL && PENABLE &&
                      (sel == pwmie_pkg::PWMIE_SEL_NONE);
    assign setup_rd = PSEL && !PENABLE && !PWRITE;
    assign acc_wr   = PSEL && PENABLE && PWRITE;

    assign wr_swbrk    = acc_wr && (sel == pwmie_pkg::PWMIE_SEL_SWBRK);
    assign wr_evt_en   = acc_wr && (sel == pwmie_pkg::PWMIE_SEL_EVT_EN);
    assign wr_brk_en   = acc_wr && (sel == pwmie_pkg::PWMIE_SEL_BRK_EN);
    assign wr_evt_flag = acc_wr && (sel == pwmie_pkg::PWMIE_SEL_EVT_FLAG);
    assign wr_brk_flag = acc_wr && (sel == pwmie_pkg::PWMIE_SEL_BRK_FLAG);
    assign wr_mode     = acc_wr && (sel == pwmie_pkg::PWMIE_SEL_MODE);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    pwmie_pkg::pwmie_word_type evt_en_q;
    pwmie_pkg::pwmie_word_type brk_en_q;
    pwmie_pkg::pwmie_word_type evt_flag_q;
    pwmie_pkg::pwmie_word_type evt_flag_d;
    pwmie_pkg::pwmie_word_type brk_flag_q;
    pwmie_pkg::pwmie_word_type brk_flag_d;
    pwmie_pkg::pwmie_word_type mode_q;
    logic [31:0]               prdata_q;
    logic [2:0]                lvl_sw_q;
    logic [2:0]                edge_sw_q;
    logic                      irq_q;

    logic [2:0]                compl_mode;
    logic [2:0]                updown_mode;
    logic [2:0]                lvl_trig;
    logic [2:0]                edge_trig;

    assign compl_mode  = mode_q[`PWMIE_MODE_COMPL_LSB +: 3];
    assign updown_mode = mode_q[`PWMIE_MODE_UPDN_LSB +: 3];

    // Event enables: compare-down, compare-up, period, zero
    // all four event enable fields, written in one access
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            evt_en_q <= `PWMIE_EVT_EN_RST;
        else if (CLK_EN && wr_evt_en)
            evt_en_q <= PWDATA & `PWMIE_EVT_MASK;
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            brk_en_q <= `PWMIE_BRK_EN_RST;
        else if (CLK_EN && wr_brk_en && WP_OPEN)
            brk_en_q <= PWDATA & `PWMIE_BRK_EN_MASK;
    end

    // Complementary and up-down mode control
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            mode_q <= `PWMIE_MODE_RST;
        else if (CLK_EN && wr_mode)
            mode_q <= PWDATA & `PWMIE_MODE_MASK;
    end

    ////////////////////////////////////////////////////////////////////////
    // Software brake triggers

    always_comb
    begin
        lvl_trig  = 3'h0;
        edge_trig = 3'h0;
        if (wr_swbrk && WP_OPEN)
        begin
            lvl_trig  = PWDATA[`PWMIE_BRK_LVL_LSB +: 3];
            edge_trig = PWDATA[`PWMIE_BRK_EDGE_LSB +: 3];
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            lvl_sw_q <= 3'h0;
        else if (CLK_EN)
            lvl_sw_q <= lvl_trig;
    end

    // Forced edge brake pulse
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            edge_sw_q <= 3'h0;
        else if (CLK_EN)
            edge_sw_q <= edge_trig;
    end

    assign LEVEL_BRAKE_SW = lvl_sw_q;
    assign EDGE_BRAKE_SW  = edge_sw_q;

    ////////////////////////////////////////////////////////////////////////
    // Event flags, set wins over a write-one clear

    logic [2:0]  period_evt;
    logic [31:0] evt_set;
    logic [31:0] brk_set;

    assign period_evt = (updown_mode & CENTER_HIT) |
                        (~updown_mode & PERIOD_HIT);

    assign evt_set = {2'h0, CMP_DOWN_HIT, 2'h0, CMP_UP_HIT,
                      3'h0, spread3(period_evt),
                      3'h0, spread3(ZERO_HIT)};

    assign brk_set = {18'h0, pair2ch(LEVEL_BRAKE_HIT | lvl_trig),
                      2'h0, pair2ch(EDGE_BRAKE_HIT | edge_trig)};

    // Event flags: clear first, then set, so a set wins
    always_comb
    begin
        evt_flag_d = w1c_update(evt_flag_q, wr_evt_flag, PWDATA, evt_set,
                                `PWMIE_EVT_MASK);
    end

    // Brake flags: same order, pair events land on both channels
    always_comb
    begin
        brk_flag_d = w1c_update(brk_flag_q, wr_brk_flag, PWDATA, brk_set,
                                `PWMIE_BRK_FLAG_MASK);
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            evt_flag_q <= `PWMIE_EVT_FLAG_RST;
        else if (CLK_EN)
            evt_flag_q <= evt_flag_d;
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            brk_flag_q <= `PWMIE_BRK_FLAG_RST;
        else if (CLK_EN)
            brk_flag_q <= brk_flag_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request

    logic [31:0] evt_gate;
    logic [31:0] brk_gate;
    logic        irq_d;

    // odd cmp-up bit is 2nd
    // In complementary mode flag and enable 2p+1 act as a second compare
    // of channel 2p, so each odd bit keeps gating its own flag bit.
    assign evt_gate = evt_en_q & `PWMIE_EVT_MASK;

    assign brk_gate = {18'h0, pair2ch(brk_en_q[`PWMIE_BRK_LVL_LSB +: 3]),
                       2'h0, pair2ch(brk_en_q[`PWMIE_BRK_EDGE_LSB +: 3])};

    // any enabled flag, taken from the next flag values so the
    // request moves at the same edge as the flags
    assign irq_d = |(evt_flag_d & evt_gate) | |(brk_flag_d & brk_gate);

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            irq_q <= 1'b0;
        else if (CLK_EN)
            irq_q <= irq_d;
    end

    assign IRQ = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle

    logic [31:0] rd_mux;

    always_comb
    begin
        case (sel)
            pwmie_pkg::PWMIE_SEL_EVT_EN:
                rd_mux = evt_en_view(evt_en_q, compl_mode);
            pwmie_pkg::PWMIE_SEL_BRK_EN:   rd_mux = brk_en_q;
            pwmie_pkg::PWMIE_SEL_EVT_FLAG: rd_mux = evt_flag_q;
            pwmie_pkg::PWMIE_SEL_BRK_FLAG: rd_mux = brk_flag_q;
            pwmie_pkg::PWMIE_SEL_MODE:     rd_mux = mode_q;
            default:                       rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            prdata_q <= 32'h0000_0000;
        else if (CLK_EN && setup_rd)
            prdata_q <= rd_mux;
    end

    assign PRDATA = prdata_q;

endmodule

`default_nettype wire

// ### tb/pwmie_asserts.sv
// Port-level checks for the PWM interrupt enable block.
// Assumes it is bound onto pwmie_top with one clock and NRST.
`timescale 1ns/1ps
`default_nettype none
module pwmie_asserts (
    input wire logic        CORE_CLK,        // Clock
    input wire logic        NRST,            // Reset, active low
    input wire logic        CLK_EN,          // Clock enable
    input wire logic        PSEL,            // APB select
    input wire logic        PENABLE,         // APB access
    input wire logic        PWRITE,          // APB direction
    input wire logic [11:0] PADDR,           // APB address
    input wire logic [31:0] PWDATA,          // APB write data
    input wire logic [31:0] PRDATA,          // APB read data
    input wire logic        PREADY,          // APB ready
    input wire logic        PSLVERR,         // APB error
    input wire logic        WP_OPEN,         // Lock open
    input wire logic [5:0]  CMP_DOWN_HIT,    // Down compare events
    input wire logic [2:0]  LEVEL_BRAKE_SW,  // Forced level brake
    input wire logic [2:0]  EDGE_BRAKE_SW,   // Forced edge brake
    input wire logic        IRQ              // Interrupt
);
    logic [31:0] en_q;
    wire logic   wr_acc;
    wire logic [2:0] lvl_wdata;
    assign wr_acc = PSEL && PENABLE && PWRITE && CLK_EN;
    assign lvl_wdata = PWDATA[10:8];
    // Shadow of the event enable register
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            en_q <= 32'h0;
        else if (wr_acc && PADDR == 12'h0e0)
            en_q <= PWDATA;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////
    a_ready_follow: assert property (PREADY == CLK_EN)
        else $error("ready differs from clock enable");
    a_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("error outside access phase");
    a_unmapped_err: assert property (PSEL && PENABLE && !(PADDR inside
        {12'h0dc, 12'h0e0, 12'h0e4, 12'h0e8, 12'h0ec, 12'h0f0}) |-> PSLVERR)
        else $error("unmapped access without error");
    a_irq_event: assert property (
        CLK_EN && !wr_acc && |(CMP_DOWN_HIT & en_q[29:24]) |=> IRQ)
        else $error("enabled event gave no interrupt");
    a_irq_held: assert property (IRQ && !(PSEL && PWRITE) |=> IRQ)
        else $error("interrupt dropped without a write");
    a_freeze_hold: assert property (!CLK_EN |=> $stable(IRQ) && $stable(PRDATA))
        else $error("state moved while clock disabled");
    a_trig_read: assert property (PSEL && !PENABLE && !PWRITE && CLK_EN
        && PADDR == 12'h0dc |=> PRDATA == 32'h0)
        else $error("trigger register read nonzero");
    a_sw_brake: assert property (
        wr_acc && WP_OPEN && PADDR == 12'h0dc |=>
        LEVEL_BRAKE_SW == $past(lvl_wdata) ##1 LEVEL_BRAKE_SW == 3'h0)
        else $error("level brake pulse wrong");
    a_locked_trig: assert property (
        wr_acc && !WP_OPEN && PADDR == 12'h0dc |=>
        LEVEL_BRAKE_SW == 3'h0 && EDGE_BRAKE_SW == 3'h0)
        else $error("locked trigger write acted");
    cover property (wr_acc && WP_OPEN && PADDR == 12'h0dc);
    cover property ($rose(IRQ));
    cover property (PSLVERR);
endmodule
bind pwmie_top pwmie_asserts u_chk (.CORE_CLK, .NRST, .CLK_EN, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .WP_OPEN, .CMP_DOWN_HIT, .LEVEL_BRAKE_SW, .EDGE_BRAKE_SW, .IRQ);
`default_nettype wire

// ### tb/test_pwm_interrupt_enable.sv
// Self-checking bench for the PWM interrupt enable block.
// Assumes pwmie_top answers APB in its access cycle.
`timescale 1ns/1ps
`default_nettype none
module test_pwm_interrupt_enable;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wp_open = 1'b0;
    logic [31:0] hits = 32'h0;
    logic [2:0]  ctr = 3'h0;
    logic [2:0]  brk = 3'h0;
    logic [31:0] rd;
    logic        err;
    int          n_fail = 0;
    int          check_count = 0;
    logic        irq;
    pwmie_top dut (.CORE_CLK(clk), .NRST(nrst), .CLK_EN(clk_en),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .WP_OPEN(wp_open),
        .CMP_DOWN_HIT(hits[29:24]), .CMP_UP_HIT(hits[21:16]),
        .PERIOD_HIT({hits[12], hits[10], hits[8]}), .CENTER_HIT(ctr),
        .ZERO_HIT({hits[4], hits[2], hits[0]}), .LEVEL_BRAKE_HIT(brk),
        .EDGE_BRAKE_HIT(3'h0), .LEVEL_BRAKE_SW(), .EDGE_BRAKE_SW(),
        .IRQ(irq));
    initial
    begin
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer, started right after a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_regs;
        apb(0, 12'h0e0, 32'h0);
        chk(rd, 32'h0);
        apb(1, 12'h0e4, 32'hffff_ffff);
        apb(1, 12'h0dc, 32'h0000_0707);
        apb(0, 12'h0e4, 32'h0);
        chk(rd, 32'h0);
        apb(0, 12'h0ec, 32'h0);
        chk(rd, 32'h0);
        wp_open <= 1'b1;
        apb(1, 12'h0e4, 32'hffff_ffff);
        apb(0, 12'h0e4, 32'h0);
        chk(rd, 32'h0000_0707);
        apb(0, 12'h0f4, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    task automatic t_events;
        logic [31:0] m;
        apb(1, 12'h0f0, 32'h0000_0007);
        for (int b = 0; b < 32; b++)
        begin
            m = 32'h1 << b;
            if ((m & 32'h3f3f_1515) != 32'h0)
            begin
                apb(1, 12'h0e0, m);
                hits <= m;
                @(posedge clk);
                hits <= 32'h0;
                @(posedge clk);
                chk({31'h0, irq}, 32'h1);
                apb(0, 12'h0e8, 32'h0);
                chk(rd, m);
                apb(1, 12'h0e8, m);
                @(posedge clk);
                chk({31'h0, irq}, 32'h0);
            end
        end
        apb(1, 12'h0e0, 32'hffff_ffff);
        apb(0, 12'h0e0, 32'h0);
        chk(rd, 32'h3f3f_1515);
    endtask
    task automatic t_brake;
        apb(1, 12'h0dc, 32'h0000_0101);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(0, 12'h0ec, 32'h0);
        chk(rd, 32'h0000_0303);
        apb(1, 12'h0ec, 32'h0000_0303);
        brk <= 3'h4;
        @(posedge clk);
        brk <= 3'h0;
        apb(0, 12'h0ec, 32'h0);
        chk(rd, 32'h0000_3000);
        apb(1, 12'h0ec, 32'h0000_3000);
        apb(1, 12'h0e4, 32'h0);
        apb(1, 12'h0dc, 32'h0000_0100);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1, 12'h0ec, 32'h0000_0303);
    endtask
    task automatic t_center;
        apb(1, 12'h0f0, 32'h0000_0100);
        apb(1, 12'h0e0, 32'h0000_0100);
        ctr <= 3'h1;
        @(posedge clk);
        ctr <= 3'h0;
        apb(0, 12'h0e8, 32'h0);
        chk(rd, 32'h0000_0100);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        clk_en <= 1'b0;
        repeat (2) @(posedge clk);
        clk_en <= 1'b1;
        t_regs;
        t_events;
        t_brake;
        t_center;
        finish_test;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        finish_test;
    end
endmodule
`default_nettype wire
